// File: rtl/rse_core.sv
// execution core for return, subtract-with-borrow, rotate decode and stop
// assumes apb master, synchronous pins, priority logic outside the block
//
// Functional notes
// - interrupt return pulls pc, status, decrements level
// - interrupt return restores all eight flags
// - subroutine return pulls pc only, decrements level
// - sbc computes dest minus source minus borrow
// - borrow valid when extension sign extends 47
// - sbc updates all eight flags
// - stop waits for reset, irq a, debug
// - stop gates clock off internally
// - stop idles memory port, floats data
// - reset pin wake enters reset processing
// - irq wake services highest pending interrupt
// - no pending interrupt resumes after stop
// - exit delay counts long, short, fast
// - delay select and fast exit bit positions
// - peripherals and interrupts held during delay
// - irq asserted at stop skips gating
`timescale 1ns/1ps
module rse_core import rse_pkg::*; #(
  parameter int unsigned STOP_LONG_CYC = 131070  // long stop exit delay
) (
  input wire logic pclk,              // core clock 25 MHz
  input wire logic presetn,           // async reset, active low
  input wire logic ce,                // clock enable, freezes state
  input wire logic psel,              // apb select
  input wire logic penable,           // apb enable
  input wire logic pwrite,            // apb direction
  input wire logic [7:0] paddr,       // apb byte address
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error on unmapped address
  input wire logic hw_reset_n,        // reset pin
  input wire logic ext_int_a_n,       // ext_int_a_pin, active low
  input wire logic dbg_req,           // debug request command pulse
  input wire logic int_pending,       // some interrupt pending
  output logic clk_gate_off,          // oscillator gated
  output logic port_idle,             // memory controls inactive
  output logic mem_data_oe,           // memory data drive enable
  output logic periph_hold,           // peripherals and interrupts cleared
  output logic reset_proc,            // reset processing state
  output logic service_int,           // pulse: arbitrate and service
  output logic resume_exec,           // pulse: continue after stop
  output logic debug_handoff          // pulse: control to debug logic
);
  // ----------------------------------------
  // architectural registers
  // ----------------------------------------
  logic [23:0] program_counter;      // pc
  logic [23:0] status_word;          // sr, cond_flags in low byte
  logic [23:0] stack_top_high;       // stacked pc
  logic [23:0] stack_top_low;        // stacked status
  logic [LVL_W-1:0] stack_level;     // stack pointer
  logic [23:0] op_mode_reg;          // operating mode
  logic [23:0] pll_ctrl_reg;         // clock generator control
  logic [55:0] acc_a_reg;            // accumulator a
  logic [55:0] acc_b_reg;            // accumulator b
  logic [47:0] x_reg;                // x pair
  logic [47:0] y_reg;                // y pair
  rse_state_t state_reg;             // core state
  rse_state_t state_next;            // next core state
  rse_wake_t wake_reg;               // cause of wake-up
  logic [CNT_W-1:0] cnt_reg;         // stop exit delay counter
  logic [CNT_W-1:0] cnt_load;        // selected delay
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic acc_phase = psel & penable;
  wire logic wr_now = acc_phase & pready & pwrite;  // write lands on ready edge
  wire logic mapped = (paddr <= OFS_STATE) && (paddr[1:0] == 2'b00);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  // ----------------------------------------
  // instruction decode and alu
  // ----------------------------------------
  logic is_ror;
  logic is_rti;
  logic is_rts;
  logic is_sbc;
  logic is_stop;
  logic src_y;
  logic dest_b;
  logic [55:0] sbc_res;
  logic [7:0] sbc_flags;
  rse_decode u_dec (
    .opcode(pwdata[23:0]),
    .is_ror(is_ror),
    .is_rti(is_rti),
    .is_rts(is_rts),
    .is_sbc(is_sbc),
    .is_stop(is_stop),
    .src_y(src_y),
    .dest_b(dest_b)
  );
  rse_sbc_alu u_alu (
    .dst(dest_b ? acc_b_reg : acc_a_reg),
    .src(src_y ? y_reg : x_reg),
    .flags(status_word[7:0]),
    .result(sbc_res),
    .flags_next(sbc_flags)
  );
  // instructions are only taken while the core runs
  wire logic exec = ce & wr_now & hit(paddr, OFS_INSTR) & (state_reg == ST_RUN);
  wire logic do_rti = exec & is_rti;
  wire logic do_rts = exec & is_rts;
  wire logic do_sbc = exec & is_sbc;
  wire logic do_stop = exec & is_stop;
  wire logic sw_wr = ce & wr_now;
  // ----------------------------------------
  // stop sequencing
  // ----------------------------------------
  wire logic fast_sel = pll_ctrl_reg[FAST_BIT];
  wire logic sd_sel = op_mode_reg[SD_BIT];
  // fast exit wins over the delay select
  assign cnt_load = fast_sel ? CNT_W'(FAST_DELAY_CYC) :
                    sd_sel ? CNT_W'(SHORT_DELAY_CYC) : CNT_W'(STOP_LONG_CYC);
  wire logic cnt_done = (state_reg == ST_DELAY) && (cnt_reg == CNT_W'(1));
  wire logic in_stop = (state_reg == ST_STOP);
  wire logic wake_rst = in_stop & ~hw_reset_n;
  wire logic wake_irq = in_stop & hw_reset_n & ~ext_int_a_n;
  wire logic wake_dbg = in_stop & hw_reset_n & ext_int_a_n & dbg_req;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        // irq a already low at stop: no gating, delay only
        if (do_stop) begin
          state_next = ext_int_a_n ? ST_STOP : ST_DELAY;
        end
      end
      ST_STOP: begin
        // nothing else moves until one wake source appears
        if (wake_rst) begin
          state_next = ST_RSTPROC;
        end else if (wake_irq | wake_dbg) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RSTPROC: begin
        if (hw_reset_n) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end
  // state, wake cause and delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
      wake_reg <= WK_NONE;
      cnt_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      if (do_stop) begin
        wake_reg <= ext_int_a_n ? WK_NONE : WK_IRQ;
      end else if (wake_irq) begin
        wake_reg <= WK_IRQ;
      end else if (wake_dbg) begin
        wake_reg <= WK_DBG;
      end
      if (state_next == ST_DELAY && state_reg != ST_DELAY) begin
        cnt_reg <= cnt_load;
      end else if (state_reg == ST_DELAY) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end
  // ----------------------------------------
  // stop side outputs
  // ----------------------------------------
  // all registered so the pins never glitch while the clock is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gate_off <= 1'b0;
      port_idle <= 1'b0;
      mem_data_oe <= 1'b1;
      periph_hold <= 1'b0;
      reset_proc <= 1'b0;
      service_int <= 1'b0;
      resume_exec <= 1'b0;
      debug_handoff <= 1'b0;
    end else if (ce) begin
      clk_gate_off <= (state_next == ST_STOP);
      port_idle <= (state_next == ST_STOP);
      mem_data_oe <= (state_next != ST_STOP);
      periph_hold <= (state_next == ST_DELAY) | (state_next == ST_STOP);
      reset_proc <= (state_next == ST_RSTPROC);
      // only one of the three exits fires when the count ends
      debug_handoff <= cnt_done & (wake_reg == WK_DBG);
      service_int <= cnt_done & (wake_reg != WK_DBG) & int_pending;
      resume_exec <= cnt_done & (wake_reg != WK_DBG) & ~int_pending;
    end
  end
  // ----------------------------------------
  // program counter, status and stack
  // ----------------------------------------
  // any other taken instruction steps the pc, so stop resumes at the next word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= RST_WORD;
      status_word <= RST_WORD;
      stack_top_high <= RST_WORD;
      stack_top_low <= RST_WORD;
      stack_level <= '0;
    end else begin
      if (do_rti | do_rts) begin
        program_counter <= stack_top_high;
        stack_level <= stack_level - LVL_W'(1);
      end else if (exec) begin
        program_counter <= program_counter + 24'h000001;
      end else if (sw_wr && hit(paddr, OFS_PC)) begin
        program_counter <= pwdata[23:0];
      end
      if (do_rti) begin
        status_word <= stack_top_low;
      end else if (do_sbc) begin
        status_word <= {status_word[23:8], sbc_flags};
      end else if (sw_wr && hit(paddr, OFS_SR)) begin
        status_word <= pwdata[23:0];
      end
      if (sw_wr && hit(paddr, OFS_STK_HI)) begin
        stack_top_high <= pwdata[23:0];
      end
      if (sw_wr && hit(paddr, OFS_STK_LO)) begin
        stack_top_low <= pwdata[23:0];
      end
      if (sw_wr && hit(paddr, OFS_STK_LVL) && !(do_rti | do_rts)) begin
        stack_level <= pwdata[LVL_W-1:0];
      end
    end
  end
  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode_reg <= RST_WORD;
      pll_ctrl_reg <= RST_WORD;
      acc_a_reg <= '0;
      acc_b_reg <= '0;
      x_reg <= '0;
      y_reg <= '0;
    end else if (sw_wr) begin
      if (hit(paddr, OFS_OPMODE)) op_mode_reg <= pwdata[23:0];
      if (hit(paddr, OFS_PLLCTL)) pll_ctrl_reg <= pwdata[23:0];
      if (do_sbc && !dest_b) acc_a_reg <= sbc_res;
      else if (hit(paddr, OFS_A_LO)) acc_a_reg[31:0] <= pwdata;
      else if (hit(paddr, OFS_A_HI)) acc_a_reg[55:32] <= pwdata[23:0];
      if (do_sbc && dest_b) acc_b_reg <= sbc_res;
      else if (hit(paddr, OFS_B_LO)) acc_b_reg[31:0] <= pwdata;
      else if (hit(paddr, OFS_B_HI)) acc_b_reg[55:32] <= pwdata[23:0];
      if (hit(paddr, OFS_X_LO)) x_reg[23:0] <= pwdata[23:0];
      if (hit(paddr, OFS_X_HI)) x_reg[47:24] <= pwdata[23:0];
      if (hit(paddr, OFS_Y_LO)) y_reg[23:0] <= pwdata[23:0];
      if (hit(paddr, OFS_Y_HI)) y_reg[47:24] <= pwdata[23:0];
    end
  end
  // ----------------------------------------
  // apb read and answer
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      OFS_OPMODE: rd_mux = {8'h00, op_mode_reg};
      OFS_PLLCTL: rd_mux = {8'h00, pll_ctrl_reg};
      OFS_STK_HI: rd_mux = {8'h00, stack_top_high};
      OFS_STK_LO: rd_mux = {8'h00, stack_top_low};
      OFS_STK_LVL: rd_mux = {28'h0000000, stack_level};
      OFS_PC: rd_mux = {8'h00, program_counter};
      OFS_SR: rd_mux = {8'h00, status_word};
      OFS_A_LO: rd_mux = acc_a_reg[31:0];
      OFS_A_HI: rd_mux = {8'h00, acc_a_reg[55:32]};
      OFS_B_LO: rd_mux = acc_b_reg[31:0];
      OFS_B_HI: rd_mux = {8'h00, acc_b_reg[55:32]};
      OFS_X_LO: rd_mux = {8'h00, x_reg[23:0]};
      OFS_X_HI: rd_mux = {8'h00, x_reg[47:24]};
      OFS_Y_LO: rd_mux = {8'h00, y_reg[23:0]};
      OFS_Y_HI: rd_mux = {8'h00, y_reg[47:24]};
      OFS_STATE: rd_mux = {26'h0000000, wake_reg, clk_gate_off, periph_hold, state_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end
  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= acc_phase & ~pready;
      pslverr <= acc_phase & ~pready & ~mapped;
      if (acc_phase & ~pready & ~pwrite) prdata <= rd_mux;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_RTI_PC: assert property (@(posedge pclk) disable iff (!presetn)
    do_rti |=> program_counter == $past(stack_top_high) && stack_level == $past(stack_level) - LVL_W'(1))
    else $error("interrupt return did not pull pc or drop level");
  AST_RTI_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    do_rti |=> status_word[7:0] == $past(stack_top_low[7:0]))
    else $error("interrupt return flags differ from stack");
  AST_RTS_SR: assert property (@(posedge pclk) disable iff (!presetn)
    do_rts |=> $stable(status_word) && program_counter == $past(stack_top_high))
    else $error("subroutine return changed status or missed pc");
  AST_SBC_DST: assert property (@(posedge pclk) disable iff (!presetn)
    do_sbc && !dest_b |=> acc_a_reg == $past(sbc_res) && status_word[7:0] == $past(sbc_flags))
    else $error("sbc result or flags not written");
  AST_ROR_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (exec && (is_ror || is_stop)) |=> $stable(status_word))
    else $error("rotate or stop touched flags");
  AST_STOP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    do_stop && ext_int_a_n |=> clk_gate_off && port_idle && !mem_data_oe)
    else $error("stop did not gate clock and idle port");
  AST_IRQ_NOGATE: assert property (@(posedge pclk) disable iff (!presetn)
    do_stop && !ext_int_a_n |=> !clk_gate_off && state_reg == ST_DELAY && periph_hold)
    else $error("stop with irq low gated clock");
  AST_FAST_CNT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_reg != ST_DELAY && state_next == ST_DELAY && fast_sel |=> cnt_reg == CNT_W'(FAST_DELAY_CYC))
    else $error("fast exit count not loaded");
  AST_RST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wake_rst |=> reset_proc && state_reg == ST_RSTPROC)
    else $error("reset pin did not enter reset processing");
  AST_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cnt_done && wake_reg == WK_IRQ && int_pending |=> service_int && !resume_exec && !periph_hold)
    else $error("interrupt not serviced at delay end");
endmodule // rse_core

// File: rtl/rse_decode.sv
// opcode classifier for the five handled instructions
// assumes a 24-bit opcode word held stable by the caller
`timescale 1ns/1ps
module rse_decode import rse_pkg::*; (
  input wire logic [23:0] opcode,  // instruction word
  output logic is_ror,             // rotate_right_op
  output logic is_rti,             // interrupt_return_op
  output logic is_rts,             // subroutine return
  output logic is_sbc,             // subtract_with_borrow_op
  output logic is_stop,            // stop
  output logic src_y,              // sbc source is y pair
  output logic dest_b              // destination is accumulator b
);
  // ----------------------------------------
  // decode terms
  // ----------------------------------------
  // upper bits of ror and sbc carry the parallel move field, so ror compares the low byte less the d bit, sbc the low byte less the d and j bits
  assign is_ror = op_match(opcode, MSK_LOW, OP_ROR);
  assign is_rti = op_match(opcode, MSK_FULL, OP_RTI);
  assign is_rts = op_match(opcode, MSK_FULL, OP_RTS);
  assign is_sbc = op_match(opcode, MSK_SBC, OP_SBC);
  assign is_stop = op_match(opcode, MSK_FULL, OP_STOP);
  assign src_y = opcode[J_BIT];
  assign dest_b = opcode[D_BIT];
endmodule // rse_decode

// File: rtl/rse_pkg.sv
// package: constants for the return, subtract and stop execution block
// assumes a 32-bit apb register bus and a 25 MHz core clock
package rse_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_OPMODE = 8'h04;
  localparam logic [7:0] OFS_PLLCTL = 8'h08;
  localparam logic [7:0] OFS_STK_HI = 8'h0C;
  localparam logic [7:0] OFS_STK_LO = 8'h10;
  localparam logic [7:0] OFS_STK_LVL = 8'h14;
  localparam logic [7:0] OFS_PC = 8'h18;
  localparam logic [7:0] OFS_SR = 8'h1C;
  localparam logic [7:0] OFS_A_LO = 8'h20;
  localparam logic [7:0] OFS_A_HI = 8'h24;
  localparam logic [7:0] OFS_B_LO = 8'h28;
  localparam logic [7:0] OFS_B_HI = 8'h2C;
  localparam logic [7:0] OFS_X_LO = 8'h30;
  localparam logic [7:0] OFS_X_HI = 8'h34;
  localparam logic [7:0] OFS_Y_LO = 8'h38;
  localparam logic [7:0] OFS_Y_HI = 8'h3C;
  localparam logic [7:0] OFS_STATE = 8'h40;
  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int SD_BIT = 6;           // stop_delay_select in op_mode_reg
  localparam int FAST_BIT = 5;         // fast_stop_exit in pll_ctrl_reg
  localparam int J_BIT = 4;            // sbc source select
  localparam int D_BIT = 3;            // destination accumulator select
  localparam int WORD_W = 24;
  localparam int LONG_W = 48;
  localparam int ACC_W = 56;
  localparam int LVL_W = 4;
  localparam int CNT_W = 17;
  localparam logic [23:0] RST_WORD = 24'h000000;
  // ----------------------------------------
  // opcode patterns (mask, value)
  // ----------------------------------------
  localparam logic [23:0] MSK_FULL = 24'hFFFFFF;
  localparam logic [23:0] MSK_LOW = 24'h0000F7;
  localparam logic [23:0] MSK_SBC = 24'h0000E7;
  localparam logic [23:0] OP_RTI = 24'h000004;
  localparam logic [23:0] OP_RTS = 24'h00000C;
  localparam logic [23:0] OP_STOP = 24'h000087;
  localparam logic [23:0] OP_ROR = 24'h000027;
  localparam logic [23:0] OP_SBC = 24'h000025;
  // ----------------------------------------
  // stop exit delays in clock cycles
  // ----------------------------------------
  localparam int SHORT_DELAY_CYC = 24;
  localparam int FAST_DELAY_HALF = 17;  // 8.5 cycles in half cycles
  localparam int FAST_DELAY_CYC = (FAST_DELAY_HALF + 1) / 2;  // rounded up
  // ----------------------------------------
  // core states and wake causes
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_DELAY = 2'b10,
    ST_RSTPROC = 2'b11
  } rse_state_t;
  typedef enum logic [1:0] {
    WK_NONE = 2'b00,
    WK_IRQ = 2'b01,
    WK_DBG = 2'b10
  } rse_wake_t;
  // opcode match used by all five instruction decode terms
  function automatic logic op_match(input logic [23:0] op, input logic [23:0] msk,
                                    input logic [23:0] val);
    op_match = ((op & msk) == val);
  endfunction
endpackage

// File: rtl/rse_sbc_alu.sv
// long subtract with borrow and its condition flags
// assumes flags ordered s,l,e,u,n,z,v,c from bit 7 down to bit 0
`timescale 1ns/1ps
module rse_sbc_alu import rse_pkg::*; (
  input wire logic [55:0] dst,    // destination accumulator
  input wire logic [47:0] src,    // x or y long word
  input wire logic [7:0] flags,   // current cond_flags
  output logic [55:0] result,     // difference
  output logic [7:0] flags_next   // updated cond_flags
);
  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  wire logic [55:0] src_ext = {{(ACC_W - LONG_W){src[LONG_W - 1]}}, src};  // sign extend
  wire logic [56:0] diff = {1'b0, dst} - {1'b0, src_ext} - {56'h00000000000000, flags[0]};
  wire logic ovf = (dst[55] ^ src_ext[55]) & (dst[55] ^ diff[55]);
  wire logic ext_used = ~((&diff[55:47]) | ~(|diff[55:47]));
  assign result = diff[55:0];
  // ----------------------------------------
  // flags by standard definition
  // ----------------------------------------
  // borrow is only meaningful across words when the extension mirrors bit 47
  assign flags_next = {flags[7] | (diff[46] ^ diff[45]),   // s sticky
                       flags[6] | ovf,                     // l sticky
                       ext_used,                           // e
                       ~(diff[47] ^ diff[46]),             // u
                       diff[55],                           // n
                       ~(|diff[55:0]),                     // z
                       ovf,                                // v
                       diff[56]};
endmodule // rse_sbc_alu

// File: tb/test_rse_core.sv
// bench for rse_core: apb master, pin driver and a small model of the block
// assumes the design answers apb by pready and holds state while ce is low
`timescale 1ns/1ps
module test_rse_core import rse_pkg::*; ;
  localparam int LONG = 40;  // shortened long exit delay
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, rd_e, c;
  logic [7:0] paddr = 8'h00, ad;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, hw_reset_n = 1, ext_int_a_n = 1, dbg_req = 0, int_pending = 0;
  logic clk_gate_off, port_idle, mem_data_oe, periph_hold, reset_proc, service_int, resume_exec, debug_handoff;
  logic [23:0] h, l, op;
  logic [47:0] s;
  logic [55:0] dst, res;
  logic [56:0] t;
  int errors = 0, n_tests = 0, cyc = 0, dcnt = 0, gate_seen = 0, n, w, d0, g0;
  rse_core #(.STOP_LONG_CYC(LONG)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_reset_n(hw_reset_n), .ext_int_a_n(ext_int_a_n), .dbg_req(dbg_req),
    .int_pending(int_pending), .clk_gate_off(clk_gate_off), .port_idle(port_idle), .mem_data_oe(mem_data_oe),
    .periph_hold(periph_hold), .reset_proc(reset_proc), .service_int(service_int), .resume_exec(resume_exec),
    .debug_handoff(debug_handoff));
  initial forever #20 pclk = ~pclk;
  // ----------------------------------------
  // monitor: exit delay length, gating seen, hang cut
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (periph_hold === 1'b1 && clk_gate_off === 1'b0) dcnt <= dcnt + 1;  // delay cycles only
    if (clk_gate_off === 1'b1) gate_seen <= gate_seen + 1;  // gated cycles, only this process writes it
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task summarize();
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [55:0] e, input logic [55:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  // one transfer, then an idle cycle so no signal is driven twice in a step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    w = 0;
    do begin @(posedge pclk); w++; end while (pready !== 1'b1 && w < 50);
    rd_v = prdata; rd_e = pslverr; psel <= 0; penable <= 0;
    if (w >= 50) begin errors++; summarize(); end
    @(posedge pclk);
  endtask
  // stop with fast/sd setting; k: 0 irq wake, 1 debug, 2 reset pin, 3 irq already low
  task stop_run(input logic f, input logic sd, input int k);
    apb(1, OFS_PLLCTL, 32'(f) << FAST_BIT); apb(1, OFS_OPMODE, 32'(sd) << SD_BIT);
    d0 = dcnt; g0 = gate_seen; int_pending <= 1'($urandom); ext_int_a_n <= (k != 3);
    apb(1, OFS_INSTR, 32'(OP_STOP)); @(posedge pclk);
    if (k != 3) chk("stop_pins", 3'b110, {clk_gate_off, port_idle, mem_data_oe});
    if (k == 0) ext_int_a_n <= 0;
    if (k == 1) dbg_req <= 1;
    if (k == 2) hw_reset_n <= 0;
    @(posedge pclk); dbg_req <= 0;
    if (k == 2) begin
      repeat (2) @(posedge pclk);
      chk("reset_proc", 1, reset_proc);
      hw_reset_n <= 1; repeat (3) @(posedge pclk);
      chk("reset_done", 0, reset_proc);
    end else begin
      n = f ? FAST_DELAY_CYC : (sd ? SHORT_DELAY_CYC : LONG);
      // clock enable low for five edges in the long delay must stretch it by five
      if (k == 0 && !f) begin
        repeat (3) @(posedge pclk);
        ce <= 0;
        repeat (5) @(posedge pclk);
        ce <= 1;
        n = n + 5;
      end
      w = 0;
      while ({service_int, resume_exec, debug_handoff} === 3'b000 && w < 300) begin @(posedge pclk); w++; end
      chk("wake", k == 1 ? 3'b001 : (int_pending ? 3'b100 : 3'b010),
          {service_int, resume_exec, debug_handoff});
      chk("delay", 56'(n), 56'(dcnt - d0));
      chk("gated", 56'(k != 3), 56'(gate_seen != g0));
      ext_int_a_n <= 1;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hC839));
    repeat (8) @(posedge pclk);
    presetn <= 1; @(posedge pclk);
    apb(0, OFS_STATE, 0); chk("state", 0, rd_v);
    apb(0, 8'h44, 0); chk("unmapped", 33'h100000000, {rd_e, rd_v});
    h = 24'($urandom); l = 24'($urandom);
    apb(1, OFS_STK_HI, 32'(h)); apb(1, OFS_STK_LO, 32'(l)); apb(1, OFS_STK_LVL, 5); apb(1, OFS_INSTR, 32'(OP_RTI));
    apb(0, OFS_PC, 0); chk("pc_rti", h, rd_v);
    apb(0, OFS_SR, 0); chk("sr_rti", l, rd_v);
    apb(0, OFS_STK_LVL, 0); chk("lvl_rti", 4, rd_v);
    h = 24'($urandom);
    apb(1, OFS_STK_HI, 32'(h)); apb(1, OFS_INSTR, 32'(OP_RTS));
    apb(0, OFS_PC, 0); chk("pc_rts", h, rd_v);
    apb(0, OFS_SR, 0); chk("sr_rts", l, rd_v);
    apb(0, OFS_STK_LVL, 0); chk("lvl_rts", 3, rd_v);
    apb(1, OFS_INSTR, 32'((24'($urandom) & ~MSK_LOW) | OP_ROR));
    apb(0, OFS_PC, 0); chk("pc_ror", 24'(h + 24'h000001), rd_v);
    apb(0, OFS_SR, 0); chk("sr_ror", l, rd_v);
    for (int i = 0; i < 4; i++) begin
      s = 48'({$urandom, $urandom}); res = 56'({$urandom, $urandom}); c = 1'($urandom);
      dst = {{8{res[47]}}, res[47:0]};  // sign-extended so the borrow is exact
      ad = i[0] ? OFS_Y_LO : OFS_X_LO;
      apb(1, OFS_SR, 32'(c)); apb(1, ad, 32'(s[23:0])); apb(1, ad + 8'h04, 32'(s[47:24]));
      ad = i[1] ? OFS_B_LO : OFS_A_LO;
      apb(1, ad, dst[31:0]); apb(1, ad + 8'h04, 32'(dst[55:32]));
      op = {16'($urandom), 8'h00} | OP_SBC | (24'(i[0]) << J_BIT) | (24'(i[1]) << D_BIT);
      apb(1, OFS_INSTR, 32'(op));
      t = {1'b0, dst} - {1'b0, {8{s[47]}}, s} - 57'(c);
      apb(0, ad, 0); res[31:0] = rd_v; apb(0, ad + 8'h04, 0); res[55:32] = rd_v[23:0];
      chk("acc", t[55:0], res);
      apb(0, OFS_SR, 0); chk("nzc", {t[55], t[55:0] == 56'h0, t[56]}, {rd_v[3], rd_v[2], rd_v[0]});
    end
    for (int i = 0; i < 6; i++) stop_run(i == 2 || i == 3, i[0], i < 4 ? i % 2 : i - 2);
    summarize();
  end
endmodule  // test_rse_core
